// [verilog/adc_dac_serial_pin_control.sv]
// Serial pin control, conversion timing and DAC register logic of the converter.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - End-of-conversion goes low when the result is ready; result valid from then.
// - In modes 00, 01, 10 each output bit changes on serial clock fall.
// - In mode 11 each output bit changes on serial clock rise.
// - Output data pin is undriven while chip select is high.
// - Serial transfers are taken only while chip select is held low.
// - Input data is sampled on each serial clock falling edge.
// - While DAC load is low, DAC outputs follow the input registers.
// - Strap high at power-up sets all DAC input registers to all ones.
// - Strap low at power-up sets all DAC input registers to all zeros.
// - Temperature result within 65 us, reference on, or 140 us, reference off.
// - Mode 10 voltage conversion within 9 us, or 80 us with reference wake-up.
// - Conversion lasts a fixed count of conversion clocks times its period.
// - Bipolar and temperature results are two's complement, others straight binary.

module cmd_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;

   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   wire [AW-1:0] wr_next = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
   wire [AW-1:0] rd_next = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;

   assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= push ? wr_next : wr_q;
         rd_q <= pop ? rd_next : rd_q;
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule : cmd_fifo

module adc_dac_serial_pin_control #(
   parameter int FIFO_WORDS = adc_dac_pin_pkg::FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output wire logic dout_o,
   output wire logic dout_oe,
   input wire logic convert_start_n,
   output logic conversion_done_n,
   input wire logic dac_load_n,
   input wire logic dac_powerup_level_select,
   input wire logic [adc_dac_pin_pkg::SAMPLE_W-1:0] adc_sample,
   input wire logic [adc_dac_pin_pkg::SAMPLE_W-1:0] temp_sample,
   output wire logic [adc_dac_pin_pkg::DAC_CHANNELS*adc_dac_pin_pkg::DAC_W-1:0] dac_codes
);
   localparam int W = adc_dac_pin_pkg::WORD_W;
   localparam int BW = adc_dac_pin_pkg::BIT_CNT_W;
   localparam int DW = adc_dac_pin_pkg::DAC_W;
   localparam int CW = adc_dac_pin_pkg::CNT_W;

   // Picks the bit of a word that goes out after cnt earlier bits, MSB first.
   function automatic logic word_bit(input logic [W-1:0] word, input logic [BW-1:0] cnt);
      logic [BW-1:0] idx;
      idx = BW'(W - 1) - cnt;
      return word[idx];
   endfunction : word_bit

   // ---------------- Serial clock domain ----------------
   // Result and clock mode are read here without synchronising. Both change only at the end
   // of a conversion or on a command, and the host reads only after end-of-conversion falls,
   // so they are static while the serial clock runs. A read during a conversion gets old data.
   logic [W-1:0] result_q;
   logic [1:0] mode_q;

   logic [BW-1:0] rx_cnt_q;
   logic [W-2:0] rx_shift_q;
   logic [W-1:0] rx_word_q;
   logic rx_tgl_q;

   // Chip select high holds the bit counter clear, so partial words are dropped.
   always_ff @(negedge sclk or posedge cs_n or negedge rstn) begin
      if (!rstn) begin
         rx_cnt_q <= '0;
         rx_shift_q <= '0;
      end else if (cs_n) begin
         rx_cnt_q <= '0;
         rx_shift_q <= '0;
      end else begin
         rx_cnt_q <= rx_cnt_q + 1'b1;
         rx_shift_q <= {rx_shift_q[W-3:0], din};
      end
   end

   // The toggle survives chip select rising; the core takes the word after it syncs the toggle.
   always_ff @(negedge sclk or negedge rstn) begin
      if (!rstn) begin
         rx_word_q <= '0;
         rx_tgl_q <= 1'b0;
      end else if (!cs_n && rx_cnt_q == BW'(W - 1)) begin
         rx_word_q <= {rx_shift_q, din};
         rx_tgl_q <= ~rx_tgl_q;
      end
   end

   logic [BW-1:0] txf_cnt_q;
   logic doutf_q;
   logic oef_q;
   logic [BW-1:0] txr_cnt_q;
   logic doutr_q;
   logic oer_q;

   always_ff @(negedge sclk or posedge cs_n or negedge rstn) begin
      if (!rstn) begin
         txf_cnt_q <= '0;
         doutf_q <= 1'b0;
         oef_q <= 1'b0;
      end else if (cs_n) begin
         txf_cnt_q <= '0;
         doutf_q <= 1'b0;
         oef_q <= 1'b0;
      end else begin
         txf_cnt_q <= txf_cnt_q + 1'b1;
         doutf_q <= word_bit(result_q, txf_cnt_q);
         oef_q <= 1'b1;
      end
   end

   always_ff @(posedge sclk or posedge cs_n or negedge rstn) begin
      if (!rstn) begin
         txr_cnt_q <= '0;
         doutr_q <= 1'b0;
         oer_q <= 1'b0;
      end else if (cs_n) begin
         txr_cnt_q <= '0;
         doutr_q <= 1'b0;
         oer_q <= 1'b0;
      end else begin
         txr_cnt_q <= txr_cnt_q + 1'b1;
         doutr_q <= word_bit(result_q, txr_cnt_q);
         oer_q <= 1'b1;
      end
   end

   wire sclk_edge_mode = (mode_q == adc_dac_pin_pkg::MODE_SCLK);
   assign dout_o = sclk_edge_mode ? doutr_q : doutf_q;
   assign dout_oe = sclk_edge_mode ? oer_q : oef_q;

   // ---------------- Core clock domain ----------------
   logic [1:0] tgl_sync_q;
   logic tgl_seen_q;
   logic [2:0] start_sync_q;
   logic [1:0] load_sync_q;
   logic [1:0] strap_sync_q;

   // Synchronisers run through reset so the strap is settled when reset releases.
   always_ff @(posedge core_clk) begin
      tgl_sync_q <= {tgl_sync_q[0], rx_tgl_q};
      start_sync_q <= {start_sync_q[1:0], convert_start_n};
      load_sync_q <= {load_sync_q[0], dac_load_n};
      strap_sync_q <= {strap_sync_q[0], dac_powerup_level_select};
   end

   wire start_rise = start_sync_q[1] & ~start_sync_q[2];
   wire rx_event = tgl_sync_q[1] ^ tgl_seen_q;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [W-1:0] cmd_word;
   wire rx_take = rx_event & fifo_in_ready;

   adc_dac_pin_pkg::conv_state_t state_q;
   wire cmd_pop = fifo_out_valid & (state_q != adc_dac_pin_pkg::CONV_RUN);

   // A full queue leaves the toggle unacknowledged; a further word before space frees is lost.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         tgl_seen_q <= 1'b0;
      end else if (rx_take) begin
         tgl_seen_q <= tgl_sync_q[1];
      end
   end

   cmd_fifo #(
      .WIDTH(W),
      .DEPTH(FIFO_WORDS)
   ) u_cmd_fifo (
      .clk(core_clk),
      .rstn(rstn),
      .in_valid(rx_event),
      .in_data(rx_word_q),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(cmd_word),
      .out_ready(cmd_pop)
   );

   // Command decode.
   wire [1:0] cmd_opc = cmd_word[adc_dac_pin_pkg::OPC_LSB +: 2];
   wire is_cfg = cmd_pop & (cmd_opc == adc_dac_pin_pkg::OPC_CONFIG);
   wire is_dac = cmd_pop & (cmd_opc == adc_dac_pin_pkg::OPC_DAC);
   wire is_conv = cmd_pop & (cmd_opc == adc_dac_pin_pkg::OPC_CONVERT);
   wire [1:0] cmd_ch = cmd_word[adc_dac_pin_pkg::DAC_CH_LSB +: 2];
   wire cmd_temp = cmd_word[adc_dac_pin_pkg::CONV_TEMP_BIT];
   wire start_on_cmd = (mode_q == adc_dac_pin_pkg::MODE_INTERNAL) || (mode_q == adc_dac_pin_pkg::MODE_SCLK);

   logic ref_on_q;
   logic bipolar_q;
   logic temp_q;
   logic [CW-1:0] wake_q;
   logic [CW-1:0] tick_q;
   logic [CW-1:0] div_q;

   // Conversion start: on the command in modes 10 and 11, on the start pin rising otherwise.
   wire go_cmd = is_conv & start_on_cmd;
   wire go_pin = (state_q == adc_dac_pin_pkg::CONV_ARMED) & start_rise;
   wire go = go_cmd | go_pin;
   wire go_temp = go_cmd ? cmd_temp : temp_q;
   wire running = (state_q == adc_dac_pin_pkg::CONV_RUN);
   wire waking = running & (wake_q != '0);
   wire conv_tick = running & ~waking & (div_q == '0);
   wire finish = conv_tick & (tick_q == CW'(1));

   // A cold reference adds its wake-up time ahead of the conversion clocks.
   wire [CW-1:0] wake_load = ref_on_q ? '0 :
      (go_temp ? CW'(adc_dac_pin_pkg::TEMP_WAKE_CYC) : CW'(adc_dac_pin_pkg::VOLT_WAKE_CYC));
   wire [CW-1:0] tick_load = go_temp ? CW'(adc_dac_pin_pkg::TEMP_CONV_CLOCKS) :
      CW'(adc_dac_pin_pkg::VOLT_CONV_CLOCKS);

   adc_dac_pin_pkg::conv_state_t state_d;
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         adc_dac_pin_pkg::CONV_IDLE: begin
            if (is_conv) begin
               state_d = start_on_cmd ? adc_dac_pin_pkg::CONV_RUN : adc_dac_pin_pkg::CONV_ARMED;
            end
         end
         adc_dac_pin_pkg::CONV_ARMED: begin
            if (go) begin
               state_d = adc_dac_pin_pkg::CONV_RUN;
            end else if (is_conv) begin
               state_d = start_on_cmd ? adc_dac_pin_pkg::CONV_RUN : adc_dac_pin_pkg::CONV_ARMED;
            end
         end
         adc_dac_pin_pkg::CONV_RUN: begin
            if (finish) begin
               state_d = adc_dac_pin_pkg::CONV_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_q <= adc_dac_pin_pkg::CONV_IDLE;
         mode_q <= adc_dac_pin_pkg::MODE_RESET;
         ref_on_q <= 1'b0;
         bipolar_q <= 1'b0;
         temp_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (is_cfg) begin
            mode_q <= cmd_word[adc_dac_pin_pkg::CFG_MODE_LSB +: 2];
            bipolar_q <= cmd_word[adc_dac_pin_pkg::CFG_BIPOLAR_BIT];
         end
         // The reference stays on after a wake-up until software turns it off.
         if (is_cfg) begin
            ref_on_q <= cmd_word[adc_dac_pin_pkg::CFG_REF_BIT];
         end else if (running & ~waking) begin
            ref_on_q <= 1'b1;
         end
         if (is_conv) begin
            temp_q <= cmd_temp;
         end
      end
   end

   // Duration is a fixed count of conversion clocks, each CONV_CLK_DIV core cycles long.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         wake_q <= '0;
         tick_q <= '0;
         div_q <= '0;
      end else if (go) begin
         wake_q <= wake_load;
         tick_q <= tick_load;
         div_q <= CW'(adc_dac_pin_pkg::CONV_CLK_DIV - 1);
      end else if (waking) begin
         wake_q <= wake_q - 1'b1;
      end else if (conv_tick) begin
         div_q <= CW'(adc_dac_pin_pkg::CONV_CLK_DIV - 1);
         tick_q <= tick_q - 1'b1;
      end else if (running) begin
         div_q <= div_q - 1'b1;
      end
   end

   // Offset-binary samples become two's complement by inverting the sign bit.
   wire twos = temp_q | bipolar_q;
   wire [adc_dac_pin_pkg::SAMPLE_W-1:0] raw = temp_q ? temp_sample : adc_sample;
   wire [adc_dac_pin_pkg::SAMPLE_W-1:0] coded = twos ? {~raw[adc_dac_pin_pkg::SAMPLE_W-1],
      raw[adc_dac_pin_pkg::SAMPLE_W-2:0]} : raw;
   wire [W-1:0] result_d = {temp_q, {(W - 1 - adc_dac_pin_pkg::SAMPLE_W){1'b0}}, coded};

   // Result and end-of-conversion change on the same edge, so data is valid once it falls.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         result_q <= adc_dac_pin_pkg::RESULT_RESET;
         conversion_done_n <= 1'b1;
      end else if (finish) begin
         result_q <= result_d;
         conversion_done_n <= 1'b0;
      end else if (go) begin
         conversion_done_n <= 1'b1;
      end
   end

   // ---------------- DAC registers ----------------
   logic init_q;
   wire [DW-1:0] init_code = strap_sync_q[1] ? adc_dac_pin_pkg::DAC_HIGH_INIT :
      adc_dac_pin_pkg::DAC_LOW_INIT;
   wire load_open = ~load_sync_q[1];

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         init_q <= 1'b1;
      end else begin
         init_q <= 1'b0;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < adc_dac_pin_pkg::DAC_CHANNELS; gi++) begin : g_dac
         logic [DW-1:0] in_q;
         logic [DW-1:0] out_q;
         wire wr = is_dac & (cmd_ch == 2'(gi));

         always_ff @(posedge core_clk) begin
            if (!rstn) begin
               in_q <= adc_dac_pin_pkg::DAC_LOW_INIT;
               out_q <= adc_dac_pin_pkg::DAC_LOW_INIT;
            end else if (init_q) begin
               in_q <= init_code;
               out_q <= init_code;
            end else begin
               in_q <= wr ? cmd_word[DW-1:0] : in_q;
               out_q <= load_open ? in_q : out_q;
            end
         end

         assign dac_codes[gi*DW +: DW] = out_q;
      end
   endgenerate
endmodule : adc_dac_serial_pin_control

`default_nettype wire

// [pkg/adc_dac_pin_pkg.sv]
// Constants, field layouts and timing counts for the converter pin-control block.
package adc_dac_pin_pkg;
   // Core clock and serial framing.
   localparam int CORE_CLK_PERIOD_NS = 50;
   localparam int WORD_W = 16;
   localparam int BIT_CNT_W = 4;
   localparam int DAC_W = 12;
   localparam int DAC_CHANNELS = 4;
   localparam int SAMPLE_W = 12;
   localparam int FIFO_DEPTH = 4;
   localparam int CNT_W = 12;

   // Clock-mode selection codes.
   localparam logic [1:0] MODE_EXT_START = 2'h0;
   localparam logic [1:0] MODE_START_INT = 2'h1;
   localparam logic [1:0] MODE_INTERNAL = 2'h2;
   localparam logic [1:0] MODE_SCLK = 2'h3;
   localparam logic [1:0] MODE_RESET = 2'h0;

   // Command word layout.
   localparam int OPC_LSB = 14;
   localparam logic [1:0] OPC_CONFIG = 2'h0;
   localparam logic [1:0] OPC_DAC = 2'h1;
   localparam logic [1:0] OPC_CONVERT = 2'h2;
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_REF_BIT = 2;
   localparam int CFG_BIPOLAR_BIT = 3;
   localparam int DAC_CH_LSB = 12;
   localparam int CONV_TEMP_BIT = 0;
   localparam int RES_TEMP_BIT = 15;

   // Reset values.
   localparam logic [DAC_W-1:0] DAC_LOW_INIT = 12'h000;
   localparam logic [DAC_W-1:0] DAC_HIGH_INIT = 12'hFFF;
   localparam logic [WORD_W-1:0] RESULT_RESET = 16'h0000;

   // Longest conversion times in microseconds.
   localparam int TEMP_REF_ON_MAX_US = 65;
   localparam int TEMP_REF_OFF_MAX_US = 140;
   localparam int VOLT_REF_ON_MAX_US = 9;
   localparam int VOLT_REF_OFF_MAX_US = 80;

   // Longest times round down to whole core cycles.
   localparam int TEMP_REF_ON_MAX_CYC = TEMP_REF_ON_MAX_US * 1000 / CORE_CLK_PERIOD_NS;
   localparam int TEMP_REF_OFF_MAX_CYC = TEMP_REF_OFF_MAX_US * 1000 / CORE_CLK_PERIOD_NS;
   localparam int VOLT_REF_ON_MAX_CYC = VOLT_REF_ON_MAX_US * 1000 / CORE_CLK_PERIOD_NS;
   localparam int VOLT_REF_OFF_MAX_CYC = VOLT_REF_OFF_MAX_US * 1000 / CORE_CLK_PERIOD_NS;

   // Cycles from a start edge on the pins to the conversion timer starting.
   localparam int START_LAT_CYC = 6;
   // Conversion clock period in core cycles.
   localparam int CONV_CLK_DIV = 12;
   localparam int TEMP_CONV_CLOCKS = (TEMP_REF_ON_MAX_CYC - START_LAT_CYC) / CONV_CLK_DIV;
   localparam int VOLT_CONV_CLOCKS = (VOLT_REF_ON_MAX_CYC - START_LAT_CYC) / CONV_CLK_DIV;
   localparam int TEMP_WAKE_CYC = TEMP_REF_OFF_MAX_CYC - START_LAT_CYC - TEMP_CONV_CLOCKS * CONV_CLK_DIV;
   localparam int VOLT_WAKE_CYC = VOLT_REF_OFF_MAX_CYC - START_LAT_CYC - VOLT_CONV_CLOCKS * CONV_CLK_DIV;

   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_ARMED,
      CONV_RUN
   } conv_state_t;
endpackage : adc_dac_pin_pkg

// [test/adc_dac_pin_asserts.sv]
// Concurrent checks on the converter pin-control ports.
`timescale 1ns/1ps
`default_nettype none
module adc_dac_pin_asserts (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic dout_oe,
   input wire logic conversion_done_n,
   input wire logic dac_load_n,
   input wire logic dac_powerup_level_select,
   input wire logic [adc_dac_pin_pkg::DAC_CHANNELS*adc_dac_pin_pkg::DAC_W-1:0] dac_codes
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   int high_cnt_q;
   logic seen_low_q;
   // The first conversion after reset is not timed, since done is high from reset on.
   always_ff @(posedge core_clk) begin
      if (!rstn || !conversion_done_n) begin
         high_cnt_q <= 0;
      end else if (seen_low_q) begin
         high_cnt_q <= high_cnt_q + 1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         seen_low_q <= 1'b0;
      end else if (!conversion_done_n) begin
         seen_low_q <= 1'b1;
      end
   end
   a_dout_off_idle: assert property (cs_n |-> !dout_oe)
      else $error("data output driven while deselected");
   a_start_outside_frame: assert property ($rose(conversion_done_n) |-> cs_n)
      else $error("conversion started inside a serial frame");
   a_strap_high_init: assert property ($rose(rstn) && dac_powerup_level_select
      |-> ##2 dac_codes == {4{adc_dac_pin_pkg::DAC_HIGH_INIT}}) else $error("dac codes not all ones");
   a_strap_low_init: assert property ($rose(rstn) && !dac_powerup_level_select
      |-> ##2 dac_codes == {4{adc_dac_pin_pkg::DAC_LOW_INIT}}) else $error("dac codes not all zeros");
   a_dac_hold_load: assert property (dac_load_n [*5] ##0 $past(rstn, 4) |-> $stable(dac_codes))
      else $error("dac outputs moved while load was high");
   a_conv_max_time: assert property (high_cnt_q <= adc_dac_pin_pkg::TEMP_REF_OFF_MAX_CYC)
      else $error("conversion ran too long");
   a_conv_min_time: assert property ($fell(conversion_done_n) && seen_low_q
      |-> high_cnt_q >= adc_dac_pin_pkg::VOLT_CONV_CLOCKS * adc_dac_pin_pkg::CONV_CLK_DIV)
      else $error("conversion shorter than its clock count");
   a_done_low_hold: assert property ($fell(conversion_done_n) |-> !conversion_done_n [*4])
      else $error("end of conversion did not hold low");
endmodule : adc_dac_pin_asserts

bind adc_dac_serial_pin_control adc_dac_pin_asserts u_asserts (.core_clk(core_clk), .rstn(rstn), .cs_n(cs_n),
   .dout_oe(dout_oe), .conversion_done_n(conversion_done_n), .dac_load_n(dac_load_n),
   .dac_powerup_level_select(dac_powerup_level_select), .dac_codes(dac_codes));
`default_nettype wire

// [test/host_spi_model.sv]
// Behavioural host serial master that frames words to the converter.
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
   output var logic sclk,
   output var logic cs_n,
   output var logic din,
   input wire logic dout
);
   // Idle low with matching phase; the serial clock stands still between frames.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b1;
   end
   task automatic xfer(input logic [15:0] w, input int nbits, input logic rise_out, output logic [15:0] r);
      r = 16'h0000;
      cs_n = 1'b0;
      // Six-nanosecond serial clock, half high and half low; data changes well clear of the fall.
      for (int i = 0; i < nbits; i++) begin
         din = w[15-i];
         #1;
         sclk = 1'b1;
         #2;
         if (rise_out) r[15-i] = dout;
         #1;
         sclk = 1'b0;
         #1;
         if (!rise_out) r[15-i] = dout;
         #1;
      end
      #3;
      cs_n = 1'b1;
      // A released data line must not look as if it still held the last bit.
      din = ~din;
   endtask : xfer
endmodule : host_spi_model
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the converter pin-control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int V_MIN = adc_dac_pin_pkg::VOLT_CONV_CLOCKS * adc_dac_pin_pkg::CONV_CLK_DIV;
   localparam int T_MIN = adc_dac_pin_pkg::TEMP_CONV_CLOCKS * adc_dac_pin_pkg::CONV_CLK_DIV;
   logic core_clk = 1'b0;
   logic rstn = 1'b1;
   logic convert_start_n = 1'b1;
   logic dac_load_n = 1'b1;
   logic strap = 1'b1;
   logic [11:0] adc_sample = 12'h9C5;
   logic [11:0] temp_sample = 12'h3A7;
   logic [15:0] rd;
   wire sclk;
   wire cs_n;
   wire din;
   wire dout_o;
   wire dout_oe;
   wire conversion_done_n;
   wire [47:0] dac_codes;
   wire dout_w = dout_oe ? dout_o : 1'bz;
   int errors = 0;
   int num_checks = 0;
   always #25 core_clk = ~core_clk;
   host_spi_model u_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_w));
   adc_dac_serial_pin_control u_dut (.core_clk(core_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout_o(dout_o), .dout_oe(dout_oe), .convert_start_n(convert_start_n),
      .conversion_done_n(conversion_done_n), .dac_load_n(dac_load_n), .dac_powerup_level_select(strap),
      .adc_sample(adc_sample), .temp_sample(temp_sample), .dac_codes(dac_codes));
   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test;
      $display("checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test
   task automatic send(input logic [15:0] w, input int n, input logic rise, input int gap);
      @(negedge core_clk);
      u_host.xfer(w, n, rise, rd);
      repeat (gap) @(negedge core_clk);
   endtask : send
   // Timed from the chip-select or start-pin rise, so command latency is inside the bound.
   task automatic conv_time(input int lo, input int hi);
      int n;
      n = 0;
      while (conversion_done_n !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      while (conversion_done_n !== 1'b0 && n < hi + 40) begin
         @(negedge core_clk);
         n++;
      end
      check("conversion done", conversion_done_n, 1'b0);
      check("conversion within bound", n <= hi, 1'b1);
      check("conversion clock count", n >= lo, 1'b1);
   endtask : conv_time
   task automatic read_result(input logic rise, input logic [15:0] exp);
      check("done before read", conversion_done_n, 1'b0);
      send(16'hC000, 16, rise, 10);
      check("result word", rd, exp);
      check("dout enable idle", dout_oe, 1'b0);
   endtask : read_result
   task automatic test_reset(input logic level);
      @(negedge core_clk);
      rstn = 1'b0;
      strap = level;
      repeat (8) @(negedge core_clk);
      rstn = 1'b1;
      repeat (3) @(negedge core_clk);
      check("dac reset codes", dac_codes, {4{level ? 12'hFFF : 12'h000}});
   endtask : test_reset
   task automatic test_dac;
      send(16'h65A3, 16, 1'b0, 10);
      send(16'h5123, 8, 1'b0, 10);
      check("dac held", dac_codes, 48'h0);
      dac_load_n = 1'b0;
      repeat (6) @(negedge core_clk);
      check("dac follow", dac_codes, 48'h0005A3000000);
      send(16'h4ABC, 16, 1'b0, 10);
      check("dac transparent", dac_codes, 48'h0005A3000ABC);
   endtask : test_dac
   task automatic test_internal;
      send(16'h0002, 16, 1'b0, 10);
      send(16'h8000, 16, 1'b0, 0);
      conv_time(V_MIN, adc_dac_pin_pkg::VOLT_REF_OFF_MAX_CYC);
      send(16'h8000, 16, 1'b0, 0);
      conv_time(V_MIN, adc_dac_pin_pkg::VOLT_REF_ON_MAX_CYC);
      read_result(1'b0, {4'h0, adc_sample});
      send(16'h8001, 16, 1'b0, 0);
      conv_time(T_MIN, adc_dac_pin_pkg::TEMP_REF_ON_MAX_CYC);
      send(16'h0007, 16, 1'b0, 10);
      read_result(1'b1, {4'h8, temp_sample ^ 12'h800});
   endtask : test_internal
   task automatic test_ext_start;
      send(16'h000C, 16, 1'b1, 10);
      send(16'h8000, 16, 1'b0, 20);
      check("armed waits for pin", conversion_done_n, 1'b0);
      convert_start_n = 1'b0;
      @(negedge core_clk);
      convert_start_n = 1'b1;
      conv_time(V_MIN, adc_dac_pin_pkg::VOLT_REF_ON_MAX_CYC);
      read_result(1'b0, {4'h0, adc_sample ^ 12'h800});
      // Mode 01 with the reference off: a temperature start from the pin includes the wake-up.
      send(16'h0001, 16, 1'b0, 10);
      send(16'h8001, 16, 1'b0, 20);
      check("armed in mode 01", conversion_done_n, 1'b0);
      convert_start_n = 1'b0;
      @(negedge core_clk);
      convert_start_n = 1'b1;
      conv_time(T_MIN, adc_dac_pin_pkg::TEMP_REF_OFF_MAX_CYC);
      read_result(1'b0, {4'h8, temp_sample ^ 12'h800});
   endtask : test_ext_start
   initial begin
      // The serial-side flops clear only on a falling reset, so reset must truly fall once.
      #1;
      rstn = 1'b0;
      test_reset(1'b1);
      test_reset(1'b0);
      test_dac();
      test_internal();
      test_ext_start();
      finish_test();
   end
   // Whole run is near 6300 cycles; this limit leaves ample margin.
   initial begin
      #2000000;
      errors++;
      finish_test();
   end
endmodule : testbench
`default_nettype wire
